// ---- hw/fsr_pkg.sv ----
package fsr_pkg;

    // ------------------------------------------------------------
    // Register selectors on the transfer port
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        FSR_SEL_IDENTITY = 3'h0,
        FSR_SEL_STATUS   = 3'h1,
        FSR_SEL_FEAT_LO  = 3'h6,
        FSR_SEL_FEAT_HI  = 3'h7,
        FSR_SEL_ENABLE   = 3'h2,
        FSR_SEL_EXC_INST = 3'h3,
        FSR_SEL_EXC_INS2 = 3'h4,
        FSR_SEL_RSVD     = 3'h5
    } fsr_sel_t;

    // ------------------------------------------------------------
    // Constant register values
    // ------------------------------------------------------------
    localparam logic [31:0] FSR_FEAT_LO_VAL = 32'h10110221;
    localparam logic [31:0] FSR_FEAT_HI_VAL = 32'h11000011;
    localparam logic [31:0] FSR_STATUS_RST = 32'h00000000;
    localparam logic [31:0] FSR_ENABLE_RST = 32'h00000000;
    // Writable status/control bits: flags, half format, NaN, flush, rounding, stride, length,
    // exceptions
    localparam logic [31:0] FSR_STATUS_WMASK = 32'hF7F7009F;
    localparam logic [31:0] FSR_EXC_MASK = 32'h0000009F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int FSR_FLAG_N = 31;
    localparam int FSR_FLAG_Z = 30;
    localparam int FSR_FLAG_C = 29;
    localparam int FSR_FLAG_V = 28;
    localparam int FSR_ALT_HALF_BIT = 26;
    localparam int FSR_DEF_NAN_BIT = 25;
    localparam int FSR_FLUSH_BIT = 24;
    localparam int FSR_RND_LO = 22;
    localparam int FSR_EN_BIT = 30;
    localparam int FSR_BOUNCE_BIT = 29;
    localparam int FSR_NS_SLOT_LO = 10;
    localparam int FSR_CPA_LO = 20;
    localparam int FSR_ID_EMUL_BIT = 23;

    // ------------------------------------------------------------
    // Coprocessor access encodings (two bits per slot)
    // ------------------------------------------------------------
    localparam logic [1:0] FSR_CPA_NONE = 2'h0;
    localparam logic [1:0] FSR_CPA_PRIV = 2'h1;
    localparam logic [1:0] FSR_CPA_FULL = 2'h3;

    // Rounding directions
    typedef enum logic [1:0] {
        FSR_RND_NEAREST = 2'h0,
        FSR_RND_PLUS    = 2'h1,
        FSR_RND_MINUS   = 2'h2,
        FSR_RND_ZERO    = 2'h3
    } fsr_rnd_t;

    // Comparison outcome from the datapath
    typedef enum logic [1:0] {
        FSR_CMP_LESS    = 2'h0,
        FSR_CMP_EQUAL   = 2'h1,
        FSR_CMP_GREATER = 2'h2,
        FSR_CMP_UNORD   = 2'h3
    } fsr_cmp_t;

endpackage : fsr_pkg

// ---- hw/fsr_gate_if.sv ----
`timescale 1ns/1ps
interface fsr_gate_if;
    import fsr_pkg::*;
    logic [3:0] slot_access;
    logic [1:0] ns_slots;
    logic secure;
    logic privileged;
    logic enabled;
    logic is_write;
    fsr_sel_t sel;
    logic permit;
    logic fp_permit;
    modport bank (output slot_access, ns_slots, secure, privileged, enabled, is_write, sel,
                  input permit, fp_permit);
    modport gate (input slot_access, ns_slots, secure, privileged, enabled, is_write, sel,
                  output permit, fp_permit);
endinterface : fsr_gate_if

// ---- hw/fsr_access_gate.sv ----
`timescale 1ns/1ps
module fsr_access_gate
    import fsr_pkg::*;
(
    fsr_gate_if.gate gi
);

    // Slot permission check, used for both the register and instruction paths
    function automatic logic fsr_slot_ok(input logic [1:0] acc, input logic priv);
        fsr_slot_ok = (acc == FSR_CPA_FULL) || (priv && acc == FSR_CPA_PRIV);
    endfunction : fsr_slot_ok

    logic slots_ok;
    logic ns_ok;

    // Both slots must agree; mismatch is unpredictable so taking the AND is safe
    assign slots_ok = fsr_slot_ok(gi.slot_access[1:0], gi.privileged)
                      && fsr_slot_ok(gi.slot_access[3:2], gi.privileged);
    assign ns_ok = gi.secure || (gi.ns_slots == 2'h3);

    // Per-mode permission matrix
    always_comb begin
        gi.permit = 1'b0;
        if (slots_ok && ns_ok) begin
            case (gi.sel)
                FSR_SEL_STATUS: gi.permit = gi.enabled;
                FSR_SEL_IDENTITY, FSR_SEL_ENABLE: gi.permit = gi.privileged;
                FSR_SEL_FEAT_LO, FSR_SEL_FEAT_HI: gi.permit = gi.privileged && !gi.is_write;
                default: gi.permit = 1'b0;
            endcase
        end
    end

    // Ordinary floating-point instructions need enable too
    assign gi.fp_permit = slots_ok && ns_ok && gi.enabled;

endmodule : fsr_access_gate

// ---- hw/fsr_status_flags.sv ----
`timescale 1ns/1ps
module fsr_status_flags
    import fsr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [31:0] wr_data,
    input wire logic cmp_valid,
    input wire fsr_cmp_t cmp_result,
    input wire logic exc_valid,
    input wire logic [7:0] exc_flags,
    output logic [31:0] status_q
);

    logic [31:0] status_d;
    logic [3:0] cmp_nzcv;

    // Comparison outcome to condition flags
    always_comb begin
        case (cmp_result)
            FSR_CMP_LESS: cmp_nzcv = 4'h8;
            FSR_CMP_EQUAL: cmp_nzcv = 4'h6;
            FSR_CMP_GREATER: cmp_nzcv = 4'h2;
            default: cmp_nzcv = 4'h3;
        endcase
    end

    // Software write first, then hardware events on top so a set is never lost
    always_comb begin
        status_d = status_q;
        if (wr_en) begin
            status_d = wr_data & FSR_STATUS_WMASK;
        end
        if (cmp_valid) begin
            status_d[FSR_FLAG_N:FSR_FLAG_V] = cmp_nzcv;
        end
        if (exc_valid) begin
            status_d = status_d | ({24'h0, exc_flags} & FSR_EXC_MASK);
        end
    end

    // Status/control word storage
    always_ff @(posedge clock) begin
        if (rst) begin
            status_q <= FSR_STATUS_RST;
        end else begin
            status_q <= status_d;
        end
    end

endmodule : fsr_status_flags

// ---- hw/fsr_register_bank.sv ----
`timescale 1ns/1ps
module fsr_register_bank
    import fsr_pkg::*;
#(
    parameter logic [7:0] IMPLEMENTER = 8'h5A, // Arbitrary value
    parameter logic [6:0] SUBARCH = 7'h02,
    parameter logic [7:0] PART = 8'hA5, // Arbitrary value
    parameter logic [3:0] VARIANT = 4'h1, // Arbitrary value
    parameter logic [3:0] REVISION = 4'h0 // Arbitrary value
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_sel,
    input wire logic [31:0] req_wdata,
    input wire logic req_privileged,
    input wire logic req_secure,
    input wire logic [3:0] coproc_access_ctrl,
    input wire logic [1:0] nonsecure_access_ctrl,
    input wire logic fp_instr_valid,
    input wire logic undef_other,
    input wire logic vector_op,
    input wire logic cmp_valid,
    input wire logic [1:0] cmp_result,
    input wire logic exc_valid,
    input wire logic [7:0] exc_flags,
    output logic resp_valid,
    output logic resp_undef,
    output logic [31:0] resp_rdata,
    output logic fp_instr_undef,
    output logic alt_half_precision,
    output logic default_nan_mode,
    output logic flush_to_zero,
    output logic [1:0] rounding_select,
    output logic toward_zero_rounding,
    output logic unit_enabled
);

    // ------------------------------------------------------------
    // Local state
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        FSR_ST_IDLE = 2'b00,
        FSR_ST_RESP = 2'b01
    } fsr_state_t;

    fsr_gate_if gi ();
    fsr_state_t state_q;
    logic en_q;
    logic bounce_q;
    logic [31:0] status_q;
    logic [31:0] identity_w;
    logic [31:0] enable_w;
    logic [31:0] rdata_d;
    logic status_wr;
    logic take;
    fsr_sel_t sel_w;

    assign sel_w = fsr_sel_t'(req_sel);
    assign take = req_valid && (state_q == FSR_ST_IDLE);

    // ------------------------------------------------------------
    // Access gating
    // ------------------------------------------------------------
    assign gi.slot_access = coproc_access_ctrl;
    assign gi.ns_slots = nonsecure_access_ctrl;
    assign gi.secure = req_secure;
    assign gi.privileged = req_privileged;
    assign gi.enabled = en_q;
    assign gi.is_write = req_write;
    assign gi.sel = sel_w;

    fsr_access_gate u_gate (
        .gi(gi.gate)
    );

    // ------------------------------------------------------------
    // Register contents
    // ------------------------------------------------------------
    // Identity is built from parameters; software-emulation bit is zero (pure hardware)
    assign identity_w = {IMPLEMENTER, 1'b0, SUBARCH, PART, VARIANT, REVISION};
    // Only enable and bounce bits exist; the rest read zero
    assign enable_w = {1'b0, en_q, bounce_q, 29'h0};

    assign status_wr = take && req_write && gi.permit && (sel_w == FSR_SEL_STATUS);

    fsr_status_flags u_flags (
        .clock(clock),
        .rst(rst),
        .wr_en(status_wr),
        .wr_data(req_wdata),
        .cmp_valid(cmp_valid),
        .cmp_result(fsr_cmp_t'(cmp_result)),
        .exc_valid(exc_valid),
        .exc_flags(exc_flags),
        .status_q(status_q)
    );

    // Global enable bit, written only through a permitted transfer
    always_ff @(posedge clock) begin
        if (rst) begin
            en_q <= FSR_ENABLE_RST[FSR_EN_BIT];
        end else if (take && req_write && gi.permit && sel_w == FSR_SEL_ENABLE) begin
            en_q <= req_wdata[FSR_EN_BIT];
        end
    end

    // Bounce flag: vector ops set it, other undefined exceptions clear it.
    // A software write loses to a same-cycle hardware event.
    always_ff @(posedge clock) begin
        if (rst) begin
            bounce_q <= FSR_ENABLE_RST[FSR_BOUNCE_BIT];
        end else if (fp_instr_valid && vector_op) begin
            bounce_q <= 1'b1;
        end else if (undef_other || (fp_instr_valid && !gi.fp_permit)) begin
            bounce_q <= 1'b0;
        end else if (take && req_write && gi.permit && sel_w == FSR_SEL_ENABLE) begin
            bounce_q <= req_wdata[FSR_BOUNCE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    always_comb begin
        case (sel_w)
            FSR_SEL_IDENTITY: rdata_d = identity_w;
            FSR_SEL_STATUS: rdata_d = status_q;
            FSR_SEL_FEAT_LO: rdata_d = FSR_FEAT_LO_VAL;
            FSR_SEL_FEAT_HI: rdata_d = FSR_FEAT_HI_VAL;
            FSR_SEL_ENABLE: rdata_d = enable_w;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // Transfer handshake: one request, one response a cycle later
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= FSR_ST_IDLE;
        end else begin
            case (state_q)
                FSR_ST_IDLE: begin
                    if (req_valid) begin
                        state_q <= FSR_ST_RESP;
                    end
                end
                FSR_ST_RESP: state_q <= FSR_ST_IDLE;
                default: state_q <= FSR_ST_IDLE;
            endcase
        end
    end

    // Response registers; refused access returns zero data with undef raised
    always_ff @(posedge clock) begin
        if (rst) begin
            resp_valid <= 1'b0;
            resp_undef <= 1'b0;
            resp_rdata <= 32'h00000000;
        end else begin
            resp_valid <= take;
            resp_undef <= take && !gi.permit;
            if (take && gi.permit && !req_write) begin
                resp_rdata <= rdata_d;
            end else if (take) begin
                resp_rdata <= 32'h00000000;
            end
        end
    end

    // Instruction gating: disabled or denied instructions are undefined
    always_ff @(posedge clock) begin
        if (rst) begin
            fp_instr_undef <= 1'b0;
        end else begin
            fp_instr_undef <= fp_instr_valid && (!gi.fp_permit || vector_op);
        end
    end

    // Control fields to the datapath, registered
    always_ff @(posedge clock) begin
        if (rst) begin
            alt_half_precision <= 1'b0;
            default_nan_mode <= 1'b0;
            flush_to_zero <= 1'b0;
            rounding_select <= FSR_RND_NEAREST;
            toward_zero_rounding <= 1'b0;
            unit_enabled <= 1'b0;
        end else begin
            alt_half_precision <= status_q[FSR_ALT_HALF_BIT];
            default_nan_mode <= status_q[FSR_DEF_NAN_BIT];
            flush_to_zero <= status_q[FSR_FLUSH_BIT];
            rounding_select <= status_q[FSR_RND_LO+:2];
            toward_zero_rounding <= (status_q[FSR_RND_LO+:2] == FSR_RND_ZERO);
            unit_enabled <= en_q;
        end
    end

    // Stride and length bits are stored but drive nothing: no vector mode

endmodule : fsr_register_bank

// ---- bench/fsr_register_bank_props.sv ----
`timescale 1ns/1ps
module fsr_register_bank_props
    import fsr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [2:0] req_sel,
    input wire logic req_privileged,
    input wire logic req_secure,
    input wire logic [3:0] coproc_access_ctrl,
    input wire logic [1:0] nonsecure_access_ctrl,
    input wire logic fp_instr_valid,
    input wire logic resp_valid,
    input wire logic resp_undef,
    input wire logic [31:0] resp_rdata,
    input wire logic fp_instr_undef,
    input wire logic [1:0] rounding_select,
    input wire logic toward_zero_rounding,
    input wire logic unit_enabled
);
    // ----------------------------------------
    // Transfer port, instruction gating and control output checks
    // ----------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // A take is a request seen while no answer stands
    logic take;
    assign take = req_valid && !resp_valid;
    answer_timing_a: assert property (take |=> resp_valid)
        else $error("no answer one cycle after a take");
    feature_const_a: assert property (take && !req_write && req_sel == 3'h6 |=>
        resp_undef || resp_rdata == FSR_FEAT_LO_VAL) else $error("feature word wrong");
    unimpl_refused_a: assert property (take && req_sel inside {3'h3, 3'h4, 3'h5} |=>
        resp_undef) else $error("unimplemented register accepted");
    user_matrix_a: assert property (take && !req_privileged && req_sel != 3'h1 |=>
        resp_undef) else $error("user access to privileged register accepted");
    nonsecure_gate_a: assert property (take && !req_secure &&
        nonsecure_access_ctrl != 2'h3 |=> resp_undef) else $error("non-secure access accepted");
    status_gate_a: assert property (take && req_sel == 3'h1 && (!unit_enabled ||
        coproc_access_ctrl[1:0] == 2'h0 || coproc_access_ctrl[3:2] == 2'h0) |=> resp_undef)
        else $error("status access accepted without slots or enable");
    refusal_data_a: assert property (resp_undef |->
        resp_valid && resp_rdata == 32'h0)
        else $error("refusal carries data");
    zero_round_a: assert property (toward_zero_rounding == (rounding_select == 2'h3))
        else $error("toward zero output disagrees with rounding field");
    disabled_undef_a: assert property (fp_instr_valid && !unit_enabled |=>
        fp_instr_undef)
        else $error("instruction accepted while disabled");
    reset_clear_a: assert property (disable iff (1'b0) rst |=>
        !resp_valid && !unit_enabled)
        else $error("outputs not cleared by reset");
endmodule : fsr_register_bank_props

bind fsr_register_bank fsr_register_bank_props u_fsr_register_bank_props (.clock, .rst,
    .req_valid, .req_write, .req_sel, .req_privileged, .req_secure, .coproc_access_ctrl,
    .nonsecure_access_ctrl, .fp_instr_valid, .resp_valid, .resp_undef, .resp_rdata,
    .fp_instr_undef, .rounding_select, .toward_zero_rounding, .unit_enabled);

// ---- bench/fsr_host_model.sv ----
`timescale 1ns/1ps
module fsr_host_model (
    input wire logic clock,
    input wire logic resp_valid,
    input wire logic resp_undef,
    input wire logic [31:0] resp_rdata,
    output logic req_valid,
    output logic req_write,
    output logic [2:0] req_sel,
    output logic [31:0] req_wdata,
    output logic req_privileged,
    output logic req_secure,
    output logic [3:0] coproc_access_ctrl,
    output logic [1:0] nonsecure_access_ctrl
);
    // ----------------------------------------
    // Core side of the transfer port
    // ----------------------------------------
    // Nothing granted out of reset
    initial begin
        {req_valid, req_write, req_privileged, req_secure} = 4'h0;
        req_sel = 3'h0;
        req_wdata = 32'h0;
        coproc_access_ctrl = 4'h0;
        nonsecure_access_ctrl = 2'h0;
    end

    // Hold the request until the answer is sampled; released lines flip so stale data shows
    task automatic xfer(input logic [2:0] a, input logic [2:0] s, input logic [31:0] d,
                        output logic [32:0] got);
        int n;
        {req_privileged, req_secure, req_write} = a;
        req_sel = s;
        req_wdata = d;
        req_valid = 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (resp_valid !== 1'b1 && n < 8);
        // A missing answer hands back unknowns so the caller's compare fails
        got = (resp_valid === 1'b1) ? {resp_undef, resp_rdata} : 'x;
        #1;
        req_valid = 1'b0;
        req_sel = ~s;
        req_wdata = ~d;
        @(posedge clock);
        #1;
    endtask : xfer

    // Non-secure slot bits first, then one identical full grant for both slots
    task automatic grant();
        nonsecure_access_ctrl = 2'h3;
        @(posedge clock);
        #1;
        coproc_access_ctrl = 4'hF;
    endtask : grant

    // Slot field changes come only from grant and here, so the lines keep one driver
    task automatic set_slots(input logic [3:0] v);
        coproc_access_ctrl = v;
    endtask : set_slots
endmodule : fsr_host_model

// ---- bench/fsr_register_bank_tb.sv ----
`timescale 1ns/1ps
module fsr_register_bank_tb;
    import fsr_pkg::*;
    typedef struct packed {logic [2:0] a; logic [2:0] s; logic [31:0] d;
        logic [32:0] e;} fsr_row_t;
    // Identity fields are arbitrary values
    localparam logic [31:0] IDENT = {8'h3C, 1'b0, 7'h02, 8'h96, 4'h2, 4'h5};
    localparam logic [32:0] REF = 33'h100000000;
    logic clock, rst, req_valid, req_write, req_privileged, req_secure;
    logic [2:0] req_sel;
    logic [31:0] req_wdata, resp_rdata;
    logic [3:0] coproc_access_ctrl;
    logic [1:0] nonsecure_access_ctrl, cmp_result, rounding_select;
    logic fp_instr_valid, undef_other, vector_op, cmp_valid, exc_valid;
    logic [7:0] exc_flags;
    logic resp_valid, resp_undef, fp_instr_undef, alt_half_precision, default_nan_mode;
    logic flush_to_zero, toward_zero_rounding, unit_enabled;
    logic [32:0] got;
    logic [3:0] flg [4] = '{4'h8, 4'h6, 4'h2, 4'h3};
    int errors = 0;
    int checks = 0;
    // Attribute bits are privileged, secure, write
    fsr_row_t rows [18] = '{'{3'h4, 3'h6, 32'h0, {1'b0, FSR_FEAT_LO_VAL}},
        '{3'h4, 3'h7, 32'h0, {1'b0, FSR_FEAT_HI_VAL}}, '{3'h4, 3'h0, 32'h0, {1'b0, IDENT}},
        '{3'h4, 3'h1, 32'h0, REF}, '{3'h6, 3'h2, 32'h0, 33'h0},
        '{3'h5, 3'h6, 32'hFFFFFFFF, REF}, '{3'h5, 3'h0, 32'hFFFFFFFF, 33'h0},
        '{3'h4, 3'h0, 32'h0, {1'b0, IDENT}}, '{3'h5, 3'h2, 32'hDFFFFFFF, 33'h0},
        '{3'h4, 3'h2, 32'h0, 33'h040000000}, '{3'h0, 3'h2, 32'h0, REF},
        '{3'h0, 3'h4, 32'h0, REF}, '{3'h4, 3'h3, 32'h0, REF}, '{3'h6, 3'h5, 32'h0, REF},
        '{3'h1, 3'h1, 32'hFFFFFFFF, 33'h0}, '{3'h0, 3'h1, 32'h0, 33'h0F7F7009F},
        '{3'h1, 3'h1, 32'h07C00000, 33'h0}, '{3'h0, 3'h1, 32'h0, 33'h007C00000}};

    fsr_register_bank #(.IMPLEMENTER(8'h3C), .SUBARCH(7'h02), .PART(8'h96), .VARIANT(4'h2),
        .REVISION(4'h5)) u_fsr_register_bank (.clock, .rst, .req_valid, .req_write, .req_sel,
        .req_wdata, .req_privileged, .req_secure, .coproc_access_ctrl, .nonsecure_access_ctrl,
        .fp_instr_valid, .undef_other, .vector_op, .cmp_valid, .cmp_result, .exc_valid,
        .exc_flags, .resp_valid, .resp_undef, .resp_rdata, .fp_instr_undef, .alt_half_precision,
        .default_nan_mode, .flush_to_zero, .rounding_select, .toward_zero_rounding,
        .unit_enabled);
    fsr_host_model u_fsr_host_model (.clock, .resp_valid, .resp_undef, .resp_rdata, .req_valid,
        .req_write, .req_sel, .req_wdata, .req_privileged, .req_secure, .coproc_access_ctrl,
        .nonsecure_access_ctrl);

    // ----------------------------------------
    // Clock, helpers and closing
    // ----------------------------------------
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick

    task automatic check(input string what, input logic [32:0] exp, input logic [32:0] seen);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results

    // A hang costs far more than the hundred-odd cycles the tests need
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        results();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        {fp_instr_valid, undef_other, vector_op, cmp_valid, exc_valid} = 5'h0;
        cmp_result = 2'h0;
        exc_flags = 8'h00;
        rst = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        rst = 1'b0;
        check("reset outputs", 33'h0, {23'h0, resp_valid, resp_undef, fp_instr_undef,
            alt_half_precision, default_nan_mode, flush_to_zero, rounding_select,
            toward_zero_rounding, unit_enabled});
        u_fsr_host_model.xfer(3'h4, 3'h6, 32'h0, got);
        check("non-secure without slots", REF, got);
        u_fsr_host_model.grant();
        $display("test reset done");
        foreach (rows[i]) begin
            u_fsr_host_model.xfer(rows[i].a, rows[i].s, rows[i].d, got);
            check("table row", rows[i].e, got);
        end
        check("controls", 33'h7F, {26'h0, alt_half_precision, default_nan_mode, flush_to_zero,
            rounding_select, toward_zero_rounding, unit_enabled});
        $display("test table done");
        for (int i = 0; i < 4; i++) begin
            tick();
            cmp_result = 2'(i);
            cmp_valid = 1'b1;
            tick();
            cmp_valid = 1'b0;
            u_fsr_host_model.xfer(3'h0, 3'h1, 32'h0, got);
            check("compare flags", {1'b0, flg[i], 28'h7C00000}, got);
        end
        for (int i = 0; i < 2; i++) begin
            tick();
            exc_flags = (i == 0) ? 8'hFF : 8'h00;
            exc_valid = 1'b1;
            tick();
            exc_valid = 1'b0;
        end
        u_fsr_host_model.xfer(3'h0, 3'h1, 32'h0, got);
        check("sticky flags", 33'h037C0009F, got);
        u_fsr_host_model.xfer(3'h1, 3'h1, 32'h0, got);
        u_fsr_host_model.xfer(3'h0, 3'h1, 32'h0, got);
        check("flags cleared", 33'h0, got);
        $display("test flags done");
        vector_op = 1'b1;
        fp_instr_valid = 1'b1;
        tick();
        {vector_op, fp_instr_valid} = 2'h0;
        u_fsr_host_model.xfer(3'h4, 3'h2, 32'h0, got);
        check("bounce set", 33'h060000000, got);
        undef_other = 1'b1;
        tick();
        undef_other = 1'b0;
        u_fsr_host_model.xfer(3'h4, 3'h2, 32'h0, got);
        check("bounce cleared", 33'h040000000, got);
        u_fsr_host_model.set_slots(4'h3);
        u_fsr_host_model.xfer(3'h0, 3'h1, 32'h0, got);
        check("one slot closed", REF, got);
        u_fsr_host_model.set_slots(4'hF);
        u_fsr_host_model.xfer(3'h5, 3'h2, 32'h0, got);
        fp_instr_valid = 1'b1;
        tick();
        fp_instr_valid = 1'b0;
        check("disabled instruction", 33'h1, {32'h0, fp_instr_undef});
        $display("test enable done");
        // Reset in mid-run must clear state that software had set
        u_fsr_host_model.xfer(3'h5, 3'h2, 32'h40000000, got);
        u_fsr_host_model.xfer(3'h1, 3'h1, 32'h01000001, got);
        check("flush set", 33'h1, {32'h0, flush_to_zero});
        rst = 1'b1;
        repeat (2) tick();
        rst = 1'b0;
        check("reset flush", 33'h0, {32'h0, flush_to_zero});
        u_fsr_host_model.xfer(3'h4, 3'h2, 32'h0, got);
        check("reset enable", 33'h0, got);
        u_fsr_host_model.xfer(3'h5, 3'h2, 32'h40000000, got);
        u_fsr_host_model.xfer(3'h0, 3'h1, 32'h0, got);
        check("reset status", 33'h0, got);
        $display("test mid reset done");
        results();
    end
endmodule : fsr_register_bank_tb
